// *** rtl/rwc_consts.svh ***
// Register offsets, fields, reset values and fault reason codes
`ifndef RWC_CONSTS_SVH
`define RWC_CONSTS_SVH
`define RWC_OFS_CTRL 12'h000
`define RWC_OFS_STATUS 12'h004
`define RWC_OFS_MASK 12'h008
`define RWC_OFS_LAST 12'h00c
`define RWC_OFS_COUNT 12'h010
`define RWC_TTM_RST 2'b00
`define RWC_TTM_SCALABLE 2'b01
`define RWC_MASK_RST 7'h00
`define RWC_STATUS_RST 7'h00
`define RWC_COUNT_RST 16'h0000
`define RWC_NCOND 7
`define RWC_B_ROOT 0
`define RWC_B_NEXT 1
`define RWC_B_RSVD 2
`define RWC_B_NOPERM 3
`define RWC_B_SSAD 4
`define RWC_B_FSNOSNP 5
`define RWC_B_FSFAIL 6
`define RWC_CA_SET 7'b0010111
`define RWC_RSN_ROOT 8'h7b
`define RWC_RSN_NEXT 8'h78
`define RWC_RSN_RSVD 8'h7a
`define RWC_RSN_NOPERM 8'h79
`define RWC_RSN_SSAD 8'h7c
`define RWC_RSN_FSNOSNP 8'h90
`define RWC_RSN_FSFAIL 8'h91
`endif

// *** rtl/rwc_pkg.sv ***
// Types shared by the walk fault classifier
package rwc_pkg;
   typedef enum logic [1:0] {
      RWC_REQ_UNTRANS,
      RWC_REQ_TRANSLATION,
      RWC_REQ_TRANSLATED,
      RWC_REQ_PAGE
   } rwc_req_t;
   typedef enum logic [1:0] {
      RWC_RESP_NONE,
      RWC_RESP_UR,
      RWC_RESP_CA,
      RWC_RESP_NOPERM
   } rwc_resp_t;
   typedef enum logic {
      RWC_IDLE,
      RWC_WALK
   } rwc_state_t;
endpackage

// *** rtl/rwc_cond_sel.sv ***
// Condition detector and priority selector for one walk step
`timescale 1ns/1ps
`default_nettype none
`include "rwc_consts.svh"
module rwc_cond_sel (
   input wire logic scalable_i,
   input wire logic nosnoop_i,
   input wire logic ss_ad_en_i,
   input wire logic nested_i,
   input wire logic fs_ad_need_i,
   input wire logic fs_ad_fail_i,
   input wire logic ss_next_err_i,
   input wire logic ss_rw_zero_i,
   input wire logic ss_and_r_zero_i,
   input wire logic ss_and_w_zero_i,
   input wire logic ss_rsvd_nz_i,
   input wire logic ss_root_err_i,
   input wire logic ss_ad_zero_i,
   input wire rwc_pkg::rwc_req_t req_i,
   output logic [`RWC_NCOND-1:0] cond_o,
   output logic [7:0] reason_o,
   output rwc_pkg::rwc_resp_t resp_o,
   output logic nonrec_o
);
   import rwc_pkg::*;
   localparam logic [7:0] RSN [0:`RWC_NCOND-1] = '{`RWC_RSN_ROOT, `RWC_RSN_NEXT,
      `RWC_RSN_RSVD, `RWC_RSN_NOPERM, `RWC_RSN_SSAD, `RWC_RSN_FSNOSNP, `RWC_RSN_FSFAIL};
   logic [`RWC_NCOND-1:0] raw;
   always_comb
   begin
      raw = '0;
      raw[`RWC_B_ROOT] = scalable_i & ss_root_err_i;
      raw[`RWC_B_NEXT] = scalable_i & ss_next_err_i;
      raw[`RWC_B_RSVD] = scalable_i & ss_rsvd_nz_i & ~ss_rw_zero_i;
      raw[`RWC_B_NOPERM] = scalable_i & (ss_rw_zero_i | (ss_and_r_zero_i & ss_and_w_zero_i));
      raw[`RWC_B_SSAD] = scalable_i & nosnoop_i & ss_ad_en_i & ss_ad_zero_i;
      // Nested first-stage fetches report only second-stage conditions
      raw[`RWC_B_FSNOSNP] = ~nested_i & nosnoop_i & fs_ad_need_i;
      raw[`RWC_B_FSFAIL] = ~nested_i & fs_ad_fail_i;
   end
   // Lowest bit wins, so a step never reports two conditions
   always_comb
   begin
      cond_o = '0;
      reason_o = 8'h00;
      for (int i = `RWC_NCOND - 1; i >= 0; i--)
      begin
         if (raw[i])
         begin
            cond_o = '0;
            cond_o[i] = 1'b1;
            reason_o = RSN[i];
         end
      end
   end
   always_comb
   begin
      if (cond_o == '0)
         resp_o = RWC_RESP_NONE;
      else if (req_i == RWC_REQ_UNTRANS)
         resp_o = RWC_RESP_UR;
      else if ((cond_o & `RWC_CA_SET) != '0)
         resp_o = RWC_RESP_CA;
      else
         resp_o = RWC_RESP_NOPERM;
      nonrec_o = (req_i == RWC_REQ_TRANSLATION) & cond_o[`RWC_B_FSFAIL];
   end
endmodule
`default_nettype wire

// *** rtl/rwc_fault_top.sv ***
// Walk fault classifier with APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rwc_consts.svh"
// Overview of operation
// - Non-snoop first-stage A/D update gives 90h
// - Failed first-stage flag update gives 91h, non-recoverable for translation requests
// - Scalable lower second-stage fetch error gives 78h
// - Second-stage entry without permission gives 79h
// - Second-stage reserved bits with permission give 7Ah
// - Second-stage root fetch error gives 7Bh
// - Non-snoop second-stage A/D bit clear gives 7Ch
// - Nested first-stage fetches report only second-stage faults; their first-stage conditions are dropped
module rwc_fault_top #(
   parameter logic WALK_COHERENT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic walk_start_i,
   input wire rwc_pkg::rwc_req_t req_type_i,
   input wire logic walk_snoop_bit_i,
   input wire logic second_stage_ad_enable_i,
   input wire logic walk_step_i,
   input wire logic nested_fs_access_i,
   input wire logic fs_ad_need_i,
   input wire logic fs_ad_fail_i,
   input wire logic ss_next_fetch_err_i,
   input wire logic ss_entry_rw_zero_i,
   input wire logic ss_and_r_zero_i,
   input wire logic ss_and_w_zero_i,
   input wire logic ss_rsvd_nonzero_i,
   input wire logic ss_root_fetch_err_i,
   input wire logic ss_ad_bit_zero_i,
   input wire logic walk_done_i,
   output logic fault_valid_o,
   output logic [7:0] fault_reason_o,
   output rwc_pkg::rwc_resp_t fault_resp_o,
   output logic fault_nonrec_o,
   output logic irq_o
);
   import rwc_pkg::*;

   logic rst_meta_b, rst_n, ctx_snoop, ctx_second_stage_ad_enable, ctx_nosnoop, ctx_untr, step_ok, cur_hit;
   logic sel_nonrec, hold_hit, hold_nonrec, report, next_nonrec, apb_acc, apb_wr, rd_err;
   logic [1:0] translation_table_mode;
   logic [`RWC_NCOND-1:0] status, mask, sel_cond, hold_cond, next_cond, status_clr;
   logic [7:0] sel_reason, hold_reason, next_reason;
   logic [15:0] count;
   logic [31:0] rd_data;
   rwc_state_t state;
   rwc_req_t ctx_req, last_req;
   rwc_resp_t sel_resp, hold_resp, next_resp, exp_ca, exp_np;

   // Reset release is synchronised; assertion stays asynchronous
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_meta_b <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_b <= 1'b1;
         rst_n <= rst_meta_b;
      end
   end

   // Walk context, latched once per walk
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= RWC_IDLE;
         ctx_req <= RWC_REQ_UNTRANS;
         ctx_snoop <= 1'b1;
         ctx_second_stage_ad_enable <= 1'b0;
      end
      else
      begin
         case (state)
            RWC_IDLE:
               // Translated and page requests never open a walk
               if (walk_start_i && (req_type_i == RWC_REQ_UNTRANS ||
                   req_type_i == RWC_REQ_TRANSLATION))
               begin
                  state <= RWC_WALK;
                  ctx_req <= req_type_i;
                  ctx_snoop <= walk_snoop_bit_i;
                  ctx_second_stage_ad_enable <= second_stage_ad_enable_i;
               end
            RWC_WALK:
               if (walk_done_i)
                  state <= RWC_IDLE;
            default:
               state <= RWC_IDLE;
         endcase
      end
   end

   assign ctx_nosnoop = ~WALK_COHERENT | ~ctx_snoop;
   assign ctx_untr = (ctx_req == RWC_REQ_UNTRANS);
   assign exp_ca = ctx_untr ? RWC_RESP_UR : RWC_RESP_CA;
   assign exp_np = ctx_untr ? RWC_RESP_UR : RWC_RESP_NOPERM;
   assign step_ok = (state == RWC_WALK) & walk_step_i;

   rwc_cond_sel u_sel (
      .scalable_i(translation_table_mode == `RWC_TTM_SCALABLE),
      .nosnoop_i(ctx_nosnoop),
      .ss_ad_en_i(ctx_second_stage_ad_enable),
      .nested_i(nested_fs_access_i),
      .fs_ad_need_i(fs_ad_need_i),
      .fs_ad_fail_i(fs_ad_fail_i),
      .ss_next_err_i(ss_next_fetch_err_i),
      .ss_rw_zero_i(ss_entry_rw_zero_i),
      .ss_and_r_zero_i(ss_and_r_zero_i),
      .ss_and_w_zero_i(ss_and_w_zero_i),
      .ss_rsvd_nz_i(ss_rsvd_nonzero_i),
      .ss_root_err_i(ss_root_fetch_err_i),
      .ss_ad_zero_i(ss_ad_bit_zero_i),
      .req_i(ctx_req),
      .cond_o(sel_cond),
      .reason_o(sel_reason),
      .resp_o(sel_resp),
      .nonrec_o(sel_nonrec)
   );

   assign cur_hit = step_ok & (sel_cond != '0);

   // First fault of the walk is kept; later ones are dropped
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_hit <= 1'b0;
         hold_cond <= '0;
         hold_reason <= 8'h00;
         hold_resp <= RWC_RESP_NONE;
         hold_nonrec <= 1'b0;
      end
      else if (state != RWC_WALK || walk_done_i)
         hold_hit <= 1'b0;
      else if (cur_hit && !hold_hit)
      begin
         hold_hit <= 1'b1;
         hold_cond <= sel_cond;
         hold_reason <= sel_reason;
         hold_resp <= sel_resp;
         hold_nonrec <= sel_nonrec;
      end
   end

   assign report = (state == RWC_WALK) & walk_done_i & (hold_hit | cur_hit);
   assign next_cond = hold_hit ? hold_cond : sel_cond;
   assign next_reason = hold_hit ? hold_reason : sel_reason;
   assign next_resp = hold_hit ? hold_resp : sel_resp;
   assign next_nonrec = hold_hit ? hold_nonrec : sel_nonrec;

   // Reason, response and nonrec outputs hold the last fault until the next one; fault_valid_o pulses
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_valid_o <= 1'b0;
         fault_reason_o <= 8'h00;
         fault_resp_o <= RWC_RESP_NONE;
         fault_nonrec_o <= 1'b0;
         last_req <= RWC_REQ_UNTRANS;
         count <= `RWC_COUNT_RST;
      end
      else
      begin
         fault_valid_o <= report;
         if (report)
         begin
            fault_reason_o <= next_reason;
            fault_resp_o <= next_resp;
            fault_nonrec_o <= next_nonrec;
            last_req <= ctx_req;
            count <= count + 16'h0001;
         end
      end
   end

   // APB: one wait state so read data comes from a flop
   assign apb_acc = psel_i & penable_i & pready_o;
   assign apb_wr = apb_acc & pwrite_i & ~rd_err;

   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr_i)
         `RWC_OFS_CTRL: rd_data = {29'h0, WALK_COHERENT, translation_table_mode};
         `RWC_OFS_STATUS: rd_data = {25'h0, status};
         `RWC_OFS_MASK: rd_data = {25'h0, mask};
         `RWC_OFS_LAST: rd_data = {19'h0, last_req, fault_nonrec_o, fault_resp_o,
            fault_reason_o};
         `RWC_OFS_COUNT: rd_data = {16'h0, count};
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o <= psel_i & penable_i & ~pready_o;
         prdata_o <= (psel_i && !pwrite_i) ? rd_data : 32'h0000_0000;
         pslverr_o <= psel_i & penable_i & ~pready_o & rd_err;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         translation_table_mode <= `RWC_TTM_RST;
         mask <= `RWC_MASK_RST;
      end
      else if (apb_wr)
      begin
         if (paddr_i == `RWC_OFS_CTRL)
            translation_table_mode <= pwdata_i[1:0];
         if (paddr_i == `RWC_OFS_MASK)
            mask <= pwdata_i[`RWC_NCOND-1:0];
      end
   end

   // Write one to clear; a new fault in the same cycle wins
   assign status_clr = (apb_wr && paddr_i == `RWC_OFS_STATUS) ?
      pwdata_i[`RWC_NCOND-1:0] : '0;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         status <= `RWC_STATUS_RST;
      else
         status <= (status & ~status_clr) | (report ? next_cond : '0);
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         irq_o <= 1'b0;
      else
         irq_o <= (status & mask) != '0;
   end

   property p_r01;
      @(posedge clk_i) disable iff (!rst_n)
      (fault_valid_o && fault_reason_o == `RWC_RSN_FSNOSNP) |->
         fault_resp_o == exp_np && $past(ctx_nosnoop);
   endproperty
   a_r01: assert property (p_r01) else $error("Bad 90h report");
   property p_r02;
      @(posedge clk_i) disable iff (!rst_n)
      (fault_valid_o && fault_reason_o == `RWC_RSN_FSFAIL) |->
         fault_resp_o == exp_np && fault_nonrec_o == !ctx_untr;
   endproperty
   a_r02: assert property (p_r02) else $error("Bad 91h report");
   property p_r03;
      @(posedge clk_i) disable iff (!rst_n)
      (fault_valid_o && fault_reason_o == `RWC_RSN_NEXT) |->
         fault_resp_o == exp_ca && $past(translation_table_mode) == `RWC_TTM_SCALABLE;
   endproperty
   a_r03: assert property (p_r03) else $error("Bad 78h report");
   property p_r04;
      @(posedge clk_i) disable iff (!rst_n)
      (step_ok && walk_done_i && !hold_hit && ss_entry_rw_zero_i && !ss_root_fetch_err_i
         && !ss_next_fetch_err_i && translation_table_mode == `RWC_TTM_SCALABLE) |=>
         fault_valid_o && fault_reason_o == `RWC_RSN_NOPERM && fault_resp_o == exp_np;
   endproperty
   a_r04: assert property (p_r04) else $error("Missing 79h report");

   property p_r05;
      @(posedge clk_i) disable iff (!rst_n)
      (fault_valid_o && fault_reason_o == `RWC_RSN_RSVD) |-> fault_resp_o == exp_ca;
   endproperty
   a_r05: assert property (p_r05) else $error("Bad 7Ah report");
   property p_r06;
      @(posedge clk_i) disable iff (!rst_n)
      (step_ok && walk_done_i && !hold_hit && ss_root_fetch_err_i &&
         translation_table_mode == `RWC_TTM_SCALABLE) |=>
         fault_valid_o && fault_reason_o == `RWC_RSN_ROOT && fault_resp_o == exp_ca;
   endproperty
   a_r06: assert property (p_r06) else $error("Missing 7Bh report");

   property p_r07;
      @(posedge clk_i) disable iff (!rst_n)
      (fault_valid_o && fault_reason_o == `RWC_RSN_SSAD) |->
         fault_resp_o == exp_ca && $past(ctx_nosnoop && ctx_second_stage_ad_enable);
   endproperty
   a_r07: assert property (p_r07) else $error("Bad 7Ch report");

   property p_r08;
      @(posedge clk_i) disable iff (!rst_n)
      (step_ok && walk_done_i && nested_fs_access_i && !hold_hit &&
         sel_cond[`RWC_NCOND-3:0] == '0) |=> !fault_valid_o;
   endproperty
   a_r08: assert property (p_r08) else $error("Nested step gave first-stage code");
   property p_r09;
      @(posedge clk_i) disable iff (!rst_n)
      (report && hold_hit) |=> fault_reason_o == $past(hold_reason);
   endproperty
   a_r09: assert property (p_r09) else $error("Later fault replaced first");

   property p_r09b;
      @(posedge clk_i) disable iff (!rst_n)
      (state == RWC_IDLE && (req_type_i == RWC_REQ_TRANSLATED ||
         req_type_i == RWC_REQ_PAGE)) |=> state == RWC_IDLE ##1 !fault_valid_o;
   endproperty
   a_r09b: assert property (p_r09b) else $error("Unchecked request walked");

   c_report: cover property (@(posedge clk_i) disable iff (!rst_n) fault_valid_o);
   c_ca: cover property (@(posedge clk_i) disable iff (!rst_n)
      fault_valid_o && fault_resp_o == RWC_RESP_CA);
   c_irq: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(irq_o));
   c_nonrec: cover property (@(posedge clk_i) disable iff (!rst_n)
      fault_valid_o && fault_nonrec_o);
endmodule
`default_nettype wire

// *** testbench/rwc_ep_model.sv ***
// Endpoint model issuing walk requests and step conditions
`timescale 1ns/1ps
`default_nettype none
module rwc_ep_model (
   input wire logic clk_i,
   output rwc_pkg::rwc_req_t req_o,
   output logic start_o,
   output logic step_o,
   output logic done_o,
   output logic snoop_o,
   output logic ad_en_o,
   output logic [9:0] cond_o
);
   import rwc_pkg::*;
   initial
   begin
      req_o = RWC_REQ_UNTRANS;
      {start_o, step_o, done_o, snoop_o, ad_en_o} = 5'h00;
      cond_o = 10'h3ff;
   end
   // Flags outside a step show junk, so a design reading them unqualified fails
   task automatic walk(input rwc_req_t r, input logic [11:0] f1, input logic [9:0] f2,
      input int n);
      @(posedge clk_i);
      start_o <= 1'b1;
      req_o <= r;
      ad_en_o <= f1[10];
      snoop_o <= f1[11];
      @(posedge clk_i);
      start_o <= 1'b0;
      step_o <= 1'b1;
      cond_o <= f1[9:0];
      done_o <= (n == 1);
      if (n == 2)
      begin
         @(posedge clk_i);
         cond_o <= f2;
         done_o <= 1'b1;
      end
      @(posedge clk_i);
      step_o <= 1'b0;
      done_o <= 1'b0;
      cond_o <= ~cond_o;
      ad_en_o <= ~f1[10];
      snoop_o <= ~f1[11];
   endtask
endmodule
`default_nettype wire

// *** testbench/remap_walk_fault_classifier_tb.sv ***
// Self-checking bench for the walk fault classifier
`timescale 1ns/1ps
`default_nettype none
module remap_walk_fault_classifier_tb;
   import rwc_pkg::*;
   // Coherent walks, so the per-walk snoop bit alone decides non-snoop faults
   localparam logic COHERENT = 1'b1;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, fault_valid_o, fault_nonrec_o, irq_o;
   logic [7:0] fault_reason_o;
   rwc_resp_t fault_resp_o;
   rwc_req_t req;
   logic start, step, done, snoop, ad_en;
   logic [9:0] cond;
   int error_cnt = 0;
   int comparisons = 0;
   int pulses = 0;
   always #10 clk = ~clk;
   always @(posedge clk) if (fault_valid_o === 1'b1) pulses <= pulses + 1;
   rwc_ep_model u_ep (.clk_i(clk), .req_o(req), .start_o(start), .step_o(step),
      .done_o(done), .snoop_o(snoop), .ad_en_o(ad_en), .cond_o(cond));
   rwc_fault_top #(.WALK_COHERENT(COHERENT)) u_dut (.clk_i(clk), .rst_b_i(rst_b),
      .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .walk_start_i(start), .req_type_i(req),
      .walk_snoop_bit_i(snoop), .second_stage_ad_enable_i(ad_en), .walk_step_i(step),
      .nested_fs_access_i(cond[9]), .fs_ad_need_i(cond[5]), .fs_ad_fail_i(cond[6]),
      .ss_next_fetch_err_i(cond[1]), .ss_entry_rw_zero_i(cond[3]), .ss_and_r_zero_i(cond[7]),
      .ss_and_w_zero_i(cond[8]), .ss_rsvd_nonzero_i(cond[2]), .ss_root_fetch_err_i(cond[0]),
      .ss_ad_bit_zero_i(cond[4]), .walk_done_i(done), .fault_valid_o(fault_valid_o),
      .fault_reason_o(fault_reason_o), .fault_resp_o(fault_resp_o),
      .fault_nonrec_o(fault_nonrec_o), .irq_o(irq_o));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Request is held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do
      begin
         @(posedge clk);
      end
      while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
      chk(er, 1'b0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
      chk(er, 1'b0);
   endtask
   task automatic wk(input rwc_req_t r, input logic [11:0] f1, input logic [9:0] f2,
      input int n, input logic ev, input logic [7:0] rsn, input rwc_resp_t rp,
      input logic nr);
      int c0;
      c0 = pulses;
      u_ep.walk(r, f1, f2, n);
      repeat (3) @(posedge clk);
      chk(pulses - c0, ev);
      if (ev)
      begin
         chk(fault_reason_o, rsn);
         chk(fault_resp_o, rp);
         chk(fault_nonrec_o, nr);
      end
   endtask
   task automatic t_reset;
      logic [31:0] rd;
      logic er;
      for (int a = 0; a <= 16; a += 4)
         rchk(a[11:0], (a == 0) ? {29'h0, COHERENT, 2'b00} : 32'h0);
      apb(1'b0, 12'h100, 32'h0, rd, er);
      chk(rd, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, 12'h002, 32'h1, rd, er);
      chk(er, 1'b1);
      $display("t_reset done");
   endtask
   task automatic t_mode;
      wr(12'h000, 32'h7);
      rchk(12'h000, {29'h0, COHERENT, 2'b11});
      wk(RWC_REQ_TRANSLATION, 12'h001, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      wr(12'h000, 32'h1);
      $display("t_mode done");
   endtask
   task automatic t_table;
      logic [7:0] rsn [7] = '{8'h7b, 8'h78, 8'h7a, 8'h79, 8'h7c, 8'h90, 8'h91};
      logic [6:0] ca = 7'b0010111;
      rwc_resp_t rp;
      for (int i = 0; i < 7; i++)
         for (int r = 0; r < 2; r++)
         begin
            rp = (r == 0) ? RWC_RESP_UR : (ca[i] ? RWC_RESP_CA : RWC_RESP_NOPERM);
            // Snoop bit clear and second-stage A/D tracking on
            wk(rwc_req_t'(r), 12'h400 | (12'h1 << i), 10'h0, 1, 1'b1, rsn[i], rp,
               r == 1 && i == 6);
         end
      rchk(12'h004, 32'h7f);
      rchk(12'h00c, 32'hf91);
      rchk(12'h010, 32'd14);
      $display("t_table done");
   endtask
   task automatic t_irq;
      chk(irq_o, 1'b0);
      wr(12'h008, 32'hffffffff);
      rchk(12'h008, 32'h7f);
      repeat (2) @(posedge clk);
      chk(irq_o, 1'b1);
      wr(12'h008, 32'h8);
      wr(12'h004, 32'h77);
      repeat (2) @(posedge clk);
      chk(irq_o, 1'b1);
      rchk(12'h004, 32'h8);
      wr(12'h004, 32'h8);
      repeat (2) @(posedge clk);
      chk(irq_o, 1'b0);
      rchk(12'h004, 32'h0);
      $display("t_irq done");
   endtask
   task automatic t_order;
      wk(RWC_REQ_TRANSLATION, 12'h004, 10'h001, 2, 1'b1, 8'h7a, RWC_RESP_CA, 1'b0);
      wk(RWC_REQ_UNTRANS, 12'h003, 10'h0, 1, 1'b1, 8'h7b, RWC_RESP_UR, 1'b0);
      wk(RWC_REQ_TRANSLATED, 12'h001, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      wk(RWC_REQ_PAGE, 12'h040, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      $display("t_order done");
   endtask
   task automatic t_nested;
      wk(RWC_REQ_UNTRANS, 12'h220, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      wk(RWC_REQ_UNTRANS, 12'h242, 10'h0, 1, 1'b1, 8'h78, RWC_RESP_UR, 1'b0);
      wk(RWC_REQ_TRANSLATION, 12'h080, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      wk(RWC_REQ_TRANSLATION, 12'h180, 10'h0, 1, 1'b1, 8'h79, RWC_RESP_NOPERM, 1'b0);
      wk(RWC_REQ_TRANSLATION, 12'h010, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      wk(RWC_REQ_UNTRANS, 12'hc20, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      wk(RWC_REQ_TRANSLATION, 12'hc10, 10'h0, 1, 1'b0, 8'h0, RWC_RESP_NONE, 1'b0);
      $display("t_nested done");
   endtask
   initial
   begin
      #200000;
      error_cnt++;
      report_and_stop();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_mode();
      t_table();
      t_irq();
      t_order();
      t_nested();
      report_and_stop();
   end
endmodule
`default_nettype wire
